// ---- rtl/tss_top.sv ----
// transmit source select: register file plus antenna and signal muxes
// assumes a single 40 MHz clock, synchronous reset and a strobe bus
// assumes the envelope pin is asynchronous, every other source on this clock
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module tss_top (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // register port
    input  wire logic [tss_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [tss_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [tss_pkg::DATA_W-1:0]     reg_rdata,
    // envelope input pin, asynchronous
    input  wire logic                           envelope_input_pin,
    // internal sources on this clock
    input  wire logic                           coder_env,
    input  wire logic                           tx_serial,
    input  wire logic                           rx_regen,
    input  wire logic                           rx_serial,
    input  wire logic                           f_rx_mod,
    input  wire logic                           f_tx_mod,
    input  wire logic                           demod_cmp,
    input  wire logic                           a_rx_rf,
    input  wire logic                           a_tx_rf,
    input  wire logic                           a_rx_unf,
    input  wire logic                           a_env_unf,
    input  wire logic [tss_pkg::TEST_BUS_W-1:0] test_bus,
    // first antenna driver pin
    output logic                                first_antenna_driver_o,
    output logic                                first_antenna_driver_oe_n,
    // second antenna driver pin
    output logic                                second_antenna_driver_o,
    output logic                                second_antenna_driver_oe_n,
    // signal output pin
    output logic                                signal_output_pin_o,
    output logic                                signal_output_pin_oe_n
);
    import tss_pkg::*;

    // register map as software sees it
    //   14h driver control, reset 80h
    //     bit 7    invert second driver while enabled
    //     bit 6    invert first driver while enabled
    //     bit 5    invert second driver while disabled
    //     bit 4    invert first driver while disabled
    //     bits 3:2 not kept, read zero
    //     bit 1    second driver enable
    //     bit 0    first driver enable
    //   16h source select, reset 10h
    //     bits 7:6 not kept, read zero
    //     bits 5:4 antenna driver source
    //     bits 3:0 signal output source
    //   20h status, read only, pin state after the output flops
    //     bit 0    first driver level
    //     bit 1    first driver driving
    //     bit 2    second driver level
    //     bit 3    second driver driving
    //     bit 4    signal pin level
    //     bit 5    signal pin driving
    //     bit 6    synchronised envelope pin
    //     bit 7    zero
    //   31h first test select, reset 00h
    //     bits 2:0 test bus line pick
    //     bits 7:3 not kept, read zero
    //   any other address reads zero and drops writes
    // enables only pick which invert bit applies; they never float a pin
    // no power-down input: outside reset only driver code 00 floats the antenna pins
    // reserved signal code 1011 drives the pin low rather than floating it
    // receive codes pass the receiver lines as they come; keeping the
    // receiver busy is the host's business

    // register state
    logic [DATA_W-1:0] tx_source_select_r;
    logic [DATA_W-1:0] driver_control_r;
    logic [DATA_W-1:0] first_test_select_r;

    // envelope pin synchroniser
    logic              env_meta_r;
    logic              env_sync_r;

    // decoded fields
    tss_drv_src_t      antenna_driver_source;
    tss_sig_src_t      signal_out_source;
    logic [2:0]        test_bus_line_pick;
    logic              invert_first_when_on;
    logic              invert_first_when_off;
    logic              invert_second_when_on;
    logic              invert_second_when_off;
    logic              first_enable;
    logic              second_enable;

    // driver and signal pin next values
    logic              drv_src_level;
    logic              drv_active;
    logic              first_level_nxt;
    logic              second_level_nxt;
    logic              sig_level_nxt;
    logic              sig_drive_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] status_byte;

    // output level for one driver: inversion depends on its enable state
    function automatic logic drv_out(input logic src, input logic en,
                                     input logic inv_on, input logic inv_off);
        logic inv;
        inv = en ? inv_on : inv_off;
        return src ^ inv;
    endfunction

    // write hit test, shared by all register processes
    function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
                                    input logic [7:0] target);
        return wr && (a == target);
    endfunction

    // two flops on the pin before anything reads it
    // envelope edges reach the antenna pins three cycles late; fine for slow envelopes
    always_ff @(posedge clk) begin
        if (srst) begin
            env_meta_r <= 1'b0;
            env_sync_r <= 1'b0;
        end else begin
            env_meta_r <= envelope_input_pin;
            env_sync_r <= env_meta_r;
        end
    end

    // source select register; reserved bits masked off on write
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_source_select_r <= TSS_TX_SOURCE_SELECT_RST;
        end else if (wr_hit(reg_wr, reg_addr, TSS_TX_SOURCE_SELECT_ADDR)) begin
            tx_source_select_r <= reg_wdata & TSS_TX_SOURCE_SELECT_MASK;
        end
    end

    // driver control: invert and enable bits
    always_ff @(posedge clk) begin
        if (srst) begin
            driver_control_r <= TSS_DRIVER_CONTROL_RST;
        end else if (wr_hit(reg_wr, reg_addr, TSS_DRIVER_CONTROL_ADDR)) begin
            driver_control_r <= reg_wdata & TSS_DRIVER_CONTROL_MASK;
        end
    end

    // test bus line pick
    always_ff @(posedge clk) begin
        if (srst) begin
            first_test_select_r <= TSS_FIRST_TEST_SELECT_RST;
        end else if (wr_hit(reg_wr, reg_addr, TSS_FIRST_TEST_SELECT_ADDR)) begin
            first_test_select_r <= reg_wdata & TSS_FIRST_TEST_SELECT_MASK;
        end
    end

    // select field decode; bits 7:6 are never looked at
    always_comb begin
        antenna_driver_source  = tss_drv_src_t'(tx_source_select_r[DRV_SRC_MSB:DRV_SRC_LSB]);
        signal_out_source      = tss_sig_src_t'(tx_source_select_r[SIG_SRC_MSB:SIG_SRC_LSB]);
        test_bus_line_pick     = first_test_select_r[TEST_PICK_MSB:TEST_PICK_LSB];
    end

    // driver control decode: invert and enable bits
    always_comb begin
        invert_first_when_on   = driver_control_r[INV_FIRST_ON_BIT];
        invert_first_when_off  = driver_control_r[INV_FIRST_OFF_BIT];
        invert_second_when_on  = driver_control_r[INV_SECOND_ON_BIT];
        invert_second_when_off = driver_control_r[INV_SECOND_OFF_BIT];
        first_enable           = driver_control_r[EN_FIRST_BIT];
        second_enable          = driver_control_r[EN_SECOND_BIT];
    end

    // shared driver source; power-down has no say, outside reset only code 00 floats the pins
    always_comb begin
        drv_src_level = 1'b0;
        drv_active    = 1'b1;
        unique case (antenna_driver_source)
            TSS_DRV_TRISTATE: drv_active = 1'b0;
            TSS_DRV_CODER:    drv_src_level = coder_env;
            TSS_DRV_ENV_PIN:  drv_src_level = env_sync_r;
            TSS_DRV_HIGH:     drv_src_level = 1'b1;
        endcase
    end

    // per-driver inversion, applied also to the constant high
    always_comb begin
        first_level_nxt  = drv_out(drv_src_level, first_enable,
                                   invert_first_when_on, invert_first_when_off);
        second_level_nxt = drv_out(drv_src_level, second_enable,
                                   invert_second_when_on, invert_second_when_off);
    end

    // signal output pick
    tss_signal_pick u_signal_pick (
        .code      (signal_out_source),
        .test_bus  (test_bus),
        .test_pick (test_bus_line_pick),
        .coder_env (coder_env),
        .tx_serial (tx_serial),
        .rx_regen  (rx_regen),
        .rx_serial (rx_serial),
        .f_rx_mod  (f_rx_mod),
        .f_tx_mod  (f_tx_mod),
        .demod_cmp (demod_cmp),
        .a_rx_rf   (a_rx_rf),
        .a_tx_rf   (a_tx_rf),
        .a_rx_unf  (a_rx_unf),
        .a_env_unf (a_env_unf),
        .level     (sig_level_nxt),
        .drive     (sig_drive_nxt)
    );

    // first antenna pin registered; floats while reset is held
    always_ff @(posedge clk) begin
        if (srst) begin
            first_antenna_driver_o     <= 1'b0;
            first_antenna_driver_oe_n  <= 1'b1;
        end else begin
            first_antenna_driver_o     <= first_level_nxt;
            first_antenna_driver_oe_n  <= ~drv_active;
        end
    end

    // second antenna pin; same code drives both, only inversion differs
    always_ff @(posedge clk) begin
        if (srst) begin
            second_antenna_driver_o    <= 1'b0;
            second_antenna_driver_oe_n <= 1'b1;
        end else begin
            second_antenna_driver_o    <= second_level_nxt;
            second_antenna_driver_oe_n <= ~drv_active;
        end
    end

    // signal output registered; glitch-free pin at the cost of one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            signal_output_pin_o    <= 1'b0;
            signal_output_pin_oe_n <= 1'b1;
        end else begin
            signal_output_pin_o    <= sig_level_nxt;
            signal_output_pin_oe_n <= ~sig_drive_nxt;
        end
    end

    // status byte from the registered pins, never from the muxes mid-change
    always_comb begin
        status_byte                        = TSS_ZERO_BYTE;
        status_byte[STAT_FIRST_LEVEL_BIT]  = first_antenna_driver_o;
        status_byte[STAT_FIRST_DRIVE_BIT]  = ~first_antenna_driver_oe_n;
        status_byte[STAT_SECOND_LEVEL_BIT] = second_antenna_driver_o;
        status_byte[STAT_SECOND_DRIVE_BIT] = ~second_antenna_driver_oe_n;
        status_byte[STAT_SIG_LEVEL_BIT]    = signal_output_pin_o;
        status_byte[STAT_SIG_DRIVE_BIT]    = ~signal_output_pin_oe_n;
        status_byte[STAT_ENV_BIT]          = env_sync_r;
    end

    // read mux; status shows what the pins carry right now
    always_comb begin
        rdata_nxt = TSS_ZERO_BYTE;
        unique case (reg_addr)
            TSS_TX_SOURCE_SELECT_ADDR:  rdata_nxt = tx_source_select_r;
            TSS_DRIVER_CONTROL_ADDR:    rdata_nxt = driver_control_r;
            TSS_FIRST_TEST_SELECT_ADDR: rdata_nxt = first_test_select_r;
            TSS_STATUS_ADDR:            rdata_nxt = status_byte;
            default: rdata_nxt = TSS_ZERO_BYTE;                // unmapped reads zero
        endcase
    end

    // read data stands only in the cycle after the strobe
    // zero otherwise, so stale data never looks like an answer
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= TSS_ZERO_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= TSS_ZERO_BYTE;
        end
    end

endmodule // tss_top

// ---- inc/tss_pkg.sv ----
// package for the transmit source select block: offsets, fields, codes
// assumes an 8-bit register port and one 40 MHz clock
package tss_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] TSS_TX_SOURCE_SELECT_ADDR = 8'h16;
    localparam logic [7:0] TSS_DRIVER_CONTROL_ADDR   = 8'h14;
    localparam logic [7:0] TSS_FIRST_TEST_SELECT_ADDR = 8'h31;
    localparam logic [7:0] TSS_STATUS_ADDR           = 8'h20;

    // reset values
    localparam logic [7:0] TSS_TX_SOURCE_SELECT_RST  = 8'h10;
    localparam logic [7:0] TSS_DRIVER_CONTROL_RST    = 8'h80;
    localparam logic [7:0] TSS_FIRST_TEST_SELECT_RST = 8'h00;
    localparam logic [7:0] TSS_ZERO_BYTE             = 8'h00;

    // tx_source_select fields
    localparam int DRV_SRC_LSB = 4;
    localparam int DRV_SRC_MSB = 5;
    localparam int SIG_SRC_LSB = 0;
    localparam int SIG_SRC_MSB = 3;
    localparam logic [7:0] TSS_TX_SOURCE_SELECT_MASK = 8'h3F;

    // driver_control fields
    localparam int INV_SECOND_ON_BIT  = 7;
    localparam int INV_FIRST_ON_BIT   = 6;
    localparam int INV_SECOND_OFF_BIT = 5;
    localparam int INV_FIRST_OFF_BIT  = 4;
    localparam int EN_SECOND_BIT      = 1;
    localparam int EN_FIRST_BIT       = 0;
    localparam logic [7:0] TSS_DRIVER_CONTROL_MASK = 8'hF3;

    // first_test_select fields
    localparam int TEST_PICK_LSB = 0;
    localparam int TEST_PICK_MSB = 2;
    localparam logic [7:0] TSS_FIRST_TEST_SELECT_MASK = 8'h07;
    localparam int TEST_BUS_W = 8;

    // status fields, all read only
    localparam int STAT_FIRST_LEVEL_BIT  = 0;
    localparam int STAT_FIRST_DRIVE_BIT  = 1;
    localparam int STAT_SECOND_LEVEL_BIT = 2;
    localparam int STAT_SECOND_DRIVE_BIT = 3;
    localparam int STAT_SIG_LEVEL_BIT    = 4;
    localparam int STAT_SIG_DRIVE_BIT    = 5;
    localparam int STAT_ENV_BIT          = 6;

    // antenna driver source codes
    typedef enum logic [1:0] {
        TSS_DRV_TRISTATE = 2'h0,
        TSS_DRV_CODER    = 2'h1,
        TSS_DRV_ENV_PIN  = 2'h2,
        TSS_DRV_HIGH     = 2'h3
    } tss_drv_src_t;

    // signal output source codes
    typedef enum logic [3:0] {
        TSS_SIG_TRISTATE   = 4'h0,
        TSS_SIG_LOW        = 4'h1,
        TSS_SIG_HIGH       = 4'h2,
        TSS_SIG_TEST_BUS   = 4'h3,
        TSS_SIG_CODER      = 4'h4,
        TSS_SIG_TX_SERIAL  = 4'h5,
        TSS_SIG_RX_REGEN   = 4'h6,
        TSS_SIG_RX_SERIAL  = 4'h7,
        TSS_SIG_F_RX_MOD   = 4'h8,
        TSS_SIG_F_TX_MOD   = 4'h9,
        TSS_SIG_F_DEMOD    = 4'hA,
        TSS_SIG_F_RSVD     = 4'hB,
        TSS_SIG_A_RX_RF    = 4'hC,
        TSS_SIG_A_TX_RF    = 4'hD,
        TSS_SIG_A_RX_UNF   = 4'hE,
        TSS_SIG_A_ENV_UNF  = 4'hF
    } tss_sig_src_t;

endpackage

// ---- rtl/tss_signal_output_pin_mux.sv ----
// combinational source pick for the signal output pin
// assumes all sources are already on the block clock
`timescale 1ns/10ps
module tss_signal_pick (
    // selection
    input  wire tss_pkg::tss_sig_src_t          code,
    input  wire logic [tss_pkg::TEST_BUS_W-1:0] test_bus,
    input  wire logic [2:0]                     test_pick,
    // internal sources
    input  wire logic                           coder_env,
    input  wire logic                           tx_serial,
    input  wire logic                           rx_regen,
    input  wire logic                           rx_serial,
    input  wire logic                           f_rx_mod,
    input  wire logic                           f_tx_mod,
    input  wire logic                           demod_cmp,
    input  wire logic                           a_rx_rf,
    input  wire logic                           a_tx_rf,
    input  wire logic                           a_rx_unf,
    input  wire logic                           a_env_unf,
    // result
    output logic                                level,
    output logic                                drive
);
    import tss_pkg::*;

    // every code is legal, so no default arm
    always_comb begin
        level = 1'b0;
        drive = 1'b1;
        unique case (code)
            TSS_SIG_TRISTATE: drive = 1'b0;
            TSS_SIG_LOW:      level = 1'b0;
            TSS_SIG_HIGH:     level = 1'b1;
            TSS_SIG_TEST_BUS: level = test_bus[test_pick];
            TSS_SIG_CODER:    level = coder_env;
            TSS_SIG_TX_SERIAL: level = tx_serial;
            TSS_SIG_RX_REGEN: level = rx_regen;
            TSS_SIG_RX_SERIAL: level = rx_serial;
            TSS_SIG_F_RX_MOD: level = f_rx_mod;
            TSS_SIG_F_TX_MOD: level = f_tx_mod;
            TSS_SIG_F_DEMOD:  level = demod_cmp;
            TSS_SIG_F_RSVD:   level = 1'b0;
            TSS_SIG_A_RX_RF:  level = a_rx_rf;
            TSS_SIG_A_TX_RF:  level = a_tx_rf;
            TSS_SIG_A_RX_UNF: level = a_rx_unf;
            TSS_SIG_A_ENV_UNF: level = a_env_unf;
        endcase
    end

endmodule // tss_signal_pick

// ---- testbench/tss_top_monitor.sv ----
// checker for the transmit source select block, bound onto tss_top
// assumes only the top-level ports are visible
`timescale 1ns/10ps
module tss_top_monitor (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       srst,
    // register port
    input wire logic [tss_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tss_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [tss_pkg::DATA_W-1:0] reg_rdata,
    // source and pins
    input wire logic                       coder_env,
    input wire logic                       first_antenna_driver_oe_n,
    input wire logic                       second_antenna_driver_oe_n,
    input wire logic                       signal_output_pin_o,
    input wire logic                       signal_output_pin_oe_n
);
    import tss_pkg::*;
    logic sel_wr;
    logic sel_rd;
    // strobes aimed at the select register
    assign sel_wr = reg_wr && (reg_addr == TSS_TX_SOURCE_SELECT_ADDR);
    assign sel_rd = reg_rd && (reg_addr == TSS_TX_SOURCE_SELECT_ADDR);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // pins settle two edges after a write strobe
    a_reset_pins:
        assert property ($fell(srst) |=> !first_antenna_driver_oe_n && signal_output_pin_oe_n)
        else $error("pins not at reset selection");
    a_sig_float:
        assert property (sel_wr && reg_wdata[3:0] == 4'h0 |-> ##2 signal_output_pin_oe_n)
        else $error("signal pin not released");
    a_sig_low:
        assert property (sel_wr && reg_wdata[3:0] == 4'h1
            |-> ##2 !signal_output_pin_oe_n && !signal_output_pin_o)
        else $error("signal pin not low");
    a_sig_high:
        assert property (sel_wr && reg_wdata[3:0] == 4'h2
            |-> ##2 !signal_output_pin_oe_n && signal_output_pin_o)
        else $error("signal pin not high");
    a_sig_coder:
        assert property (sel_wr && reg_wdata[3:0] == 4'h4
            |-> ##2 signal_output_pin_o == $past(coder_env))
        else $error("signal pin not on coder envelope");
    a_drv_float:
        assert property (sel_wr && reg_wdata[5:4] == 2'b00
            |-> ##2 first_antenna_driver_oe_n && second_antenna_driver_oe_n)
        else $error("drivers not released");
    a_drv_drive:
        assert property (sel_wr && reg_wdata[5:4] != 2'b00
            |-> ##2 !first_antenna_driver_oe_n && !second_antenna_driver_oe_n)
        else $error("drivers not driving");
    a_read_back:
        assert property (sel_wr ##1 sel_rd |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3F))
        else $error("select read back wrong");
endmodule // tss_top_monitor

bind tss_top tss_top_monitor u_tss_top_monitor (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .coder_env(coder_env),
    .first_antenna_driver_oe_n(first_antenna_driver_oe_n),
    .second_antenna_driver_oe_n(second_antenna_driver_oe_n),
    .signal_output_pin_o(signal_output_pin_o), .signal_output_pin_oe_n(signal_output_pin_oe_n));

// ---- testbench/tss_sam_model.sv ----
// stand-in for the access module on the envelope and signal pins
// assumes the bench picks the envelope level to send
`timescale 1ns/10ps
module tss_sam_model (
    // clock
    input wire logic clk,
    // envelope sent to the device
    input wire logic env_level,
    output logic     envelope_input_pin,
    // device signal pin as seen here
    input wire logic sig_o,
    input wire logic sig_oe_n,
    output logic     sig_seen
);
    logic last_r;
    initial envelope_input_pin = 1'b0;
    // moves off the device edge, as an unrelated source would
    always @(negedge clk) envelope_input_pin <= env_level;
    // a released line holds nothing: show the inverse of the last level
    always @(posedge clk) if (!sig_oe_n) last_r <= sig_o;
    assign sig_seen = sig_oe_n ? ~last_r : sig_o;
endmodule // tss_sam_model

// ---- testbench/testbench.sv ----
// self-checking bench for the transmit source select block
// assumes tss_top, its bound checker and the module stand-in
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    import tss_pkg::*;
    logic        clk, srst, reg_wr, reg_rd, env_level, env_pin, sam_rx, sig_o, sig_oe_n;
    logic        rd_d = 1'b0, lvl, exp_lvl;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, test_bus, rd_exp, rd_exp_d, dc;
    logic [10:0] src, sel;
    logic [1:0]  ant_o, ant_oe_n;
    logic [7:0]  dc_tab [4] = '{8'h00, 8'hF3, 8'h50, 8'hA1};
    int          num_errors = 0;
    int          total_checks = 0;

    tss_top u_tss_top (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .envelope_input_pin(env_pin),
        .coder_env(src[0]), .tx_serial(src[1]), .rx_regen(src[2]), .rx_serial(src[3]),
        .f_rx_mod(src[4]), .f_tx_mod(src[5]), .demod_cmp(src[6]), .a_rx_rf(src[7]),
        .a_tx_rf(src[8]), .a_rx_unf(src[9]), .a_env_unf(src[10]), .test_bus(test_bus),
        .first_antenna_driver_o(ant_o[0]), .first_antenna_driver_oe_n(ant_oe_n[0]),
        .second_antenna_driver_o(ant_o[1]), .second_antenna_driver_oe_n(ant_oe_n[1]),
        .signal_output_pin_o(sig_o), .signal_output_pin_oe_n(sig_oe_n));
    tss_sam_model u_tss_sam_model (.clk(clk), .env_level(env_level),
        .envelope_input_pin(env_pin), .sig_o(sig_o), .sig_oe_n(sig_oe_n), .sig_seen(sam_rx));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d     <= reg_rd;
        rd_exp_d <= rd_exp;
        if (rd_d) `CHK(reg_rdata, rd_exp_d)
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        reg_addr <= a;
        rd_exp   <= e;
        @(posedge clk);
    endtask

    // strobes are left up by wr/rd so that transfers can run back to back
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // a hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        srst      = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        src       = 11'h000;
        test_bus  = 8'h00;
        env_level = 1'b0;
        rd_exp    = 8'h00;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(TSS_TX_SOURCE_SELECT_ADDR, TSS_TX_SOURCE_SELECT_RST);
        rd(TSS_DRIVER_CONTROL_ADDR, TSS_DRIVER_CONTROL_RST);
        rd(8'h55, 8'h00);
        idle(3);
        `CHK(ant_oe_n, 2'b00)
        `CHK(sig_oe_n, 1'b1)
        wr(TSS_TX_SOURCE_SELECT_ADDR, 8'hFF);
        rd(TSS_TX_SOURCE_SELECT_ADDR, 8'h3F);
        wr(TSS_FIRST_TEST_SELECT_ADDR, 8'hFD);
        rd(TSS_FIRST_TEST_SELECT_ADDR, 8'h05);
        idle(2);
        $display("test registers done");
        // each source in turn carries the level, all others the inverse
        for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 2; p++) begin
                sel = (c >= 4) ? 11'h001 << ((c > 10) ? c - 5 : c - 4) : 11'h000;
                src      <= p[0] ? sel : ~sel;
                test_bus <= p[0] ? 8'h20 : 8'hDF;
                wr(TSS_TX_SOURCE_SELECT_ADDR, 8'h10 | c[7:0]);
                idle(4);
                exp_lvl = (c == 2) || (p[0] && c >= 3 && c != 11);
                `CHK(sig_oe_n, c == 0)
                if (c != 0) begin
                    `CHK(sig_o, exp_lvl)
                    `CHK(sam_rx, exp_lvl)
                end
            end
        end
        $display("test signal output done");
        // driver sources under four invert and enable mixes from dc_tab; select reserved bits set
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 4; c++) begin
                for (int p = 0; p < 2; p++) begin
                    dc = dc_tab[i];
                    src[0]    <= p[0];
                    env_level <= p[0];
                    wr(TSS_DRIVER_CONTROL_ADDR, dc);
                    wr(TSS_TX_SOURCE_SELECT_ADDR, {2'b11, c[1:0], 4'h2});
                    idle(5);
                    lvl = (c == 3) || p[0];
                    `CHK(ant_oe_n, {2{c == 0}})
                    if (c != 0) begin
                        `CHK(ant_o[0], lvl ^ (dc[0] ? dc[6] : dc[4]))
                        `CHK(ant_o[1], lvl ^ (dc[1] ? dc[7] : dc[5]))
                    end
                end
            end
        end
        rd(TSS_TX_SOURCE_SELECT_ADDR, 8'h32);
        rd(TSS_STATUS_ADDR, 8'h7B);
        idle(3);
        $display("test antenna drivers done");
        // reset again mid-run: select and pins return to the reset choice
        srst <= 1'b1;
        idle(2);
        srst <= 1'b0;
        rd(TSS_TX_SOURCE_SELECT_ADDR, TSS_TX_SOURCE_SELECT_RST);
        idle(3);
        `CHK(ant_oe_n, 2'b00)
        `CHK(sig_oe_n, 1'b1)
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // testbench
